// *** common/adcseq_regs.vh ***
// register map, field positions and timing counts of the conversion sequencer
`ifndef ADCSEQ_REGS_VH
`define ADCSEQ_REGS_VH
// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define ADCSEQ_ADDR_SELECT 12'h000
`define ADCSEQ_ADDR_CONTROL 12'h004
`define ADCSEQ_ADDR_RESULT 12'h008
`define ADCSEQ_ADDR_STATUS 12'h00C
`define ADCSEQ_ADDR_MASK 12'h010
`define ADCSEQ_ADDR_SAMPLE 12'h014
// ------------------------------------------------------------
// select register fields
// ------------------------------------------------------------
`define ADCSEQ_REF_HI 7
`define ADCSEQ_REF_LO 6
`define ADCSEQ_LADJ_BIT 5
`define ADCSEQ_CHAN_HI 4
`define ADCSEQ_SELECT_RESET 8'h00
// reference select encodings
`define ADCSEQ_REF_EXTERNAL 2'h0
`define ADCSEQ_REF_SUPPLY 2'h1
`define ADCSEQ_REF_RESERVED 2'h2
`define ADCSEQ_REF_INTERNAL 2'h3
// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define ADCSEQ_EN_BIT 7
`define ADCSEQ_START_BIT 6
`define ADCSEQ_AUTO_BIT 5
`define ADCSEQ_DIFF_BIT 4
`define ADCSEQ_PRESC_HI 2
// status and mask: bit 0 is conversion complete
`define ADCSEQ_DONE_BIT 0
// ------------------------------------------------------------
// conversion lengths in adc clock cycles
// ------------------------------------------------------------
`define ADCSEQ_CYC_NORMAL 5'd13
`define ADCSEQ_CYC_SYNC 5'd14
`define ADCSEQ_CYC_FIRST 5'd25
// gain stage settling, in microseconds and in system clocks at 25 MHz
`define ADCSEQ_SETTLE_US 125
`define ADCSEQ_CLK_MHZ 25
`define ADCSEQ_SETTLE_CYC (`ADCSEQ_SETTLE_US * `ADCSEQ_CLK_MHZ)
`endif

// *** hdl/adcseq_prescaler.v ***
// adc clock prescaler giving one-cycle adc tick pulses and the half-rate clock
`timescale 1ns/100ps
module adcseq_prescaler (
   input wire clock, // system clock
   input wire rst, // synchronous reset, active high
   input wire clkEn, // freezes state while low
   input wire clear, // restarts the division from zero
   input wire [2:0] divSel, // division is two to the power divSel, min 2
   output reg adcTick, // one-cycle pulse per adc clock edge
   output reg halfRate // toggles on each adc tick
);
   reg [7:0] count; // free running divider

   // ------------------------------------------------------------
   // divider
   // ------------------------------------------------------------
   // tick at terminal count of the selected power of two
   function isTerminal;
      input [7:0] c;
      input [2:0] s;
      reg [7:0] m;
      begin
         m = (s == 3'd0) ? 8'h01 : ((8'h01 << s) - 8'h01);
         isTerminal = ((c & m) == m);
      end
   endfunction

   always @(posedge clock) begin
      if (rst) begin
         count <= 8'h00;
         adcTick <= 1'b0;
         halfRate <= 1'b0;
      end else if (clkEn) begin
         if (clear) begin
            // restart keeps the gain clock from a known phase
            count <= 8'h00;
            adcTick <= 1'b0;
            halfRate <= 1'b0;
         end else begin
            count <= count + 8'h01;
            adcTick <= isTerminal(count, divSel);
            if (isTerminal(count, divSel)) begin
               halfRate <= ~halfRate;
            end
         end
      end
   end
endmodule // adcseq_prescaler

// *** hdl/adcseq_sequencer.v ***
// conversion sequencer with apb registers, selection buffering and interrupt
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/100ps
`include "adcseq_regs.vh"
module adcseq_sequencer (
   input wire clock, // system clock, 25 MHz
   input wire rst, // synchronous reset, active high
   input wire clkEn, // freezes all state while low
   input wire psel, // apb select
   input wire penable, // apb access phase
   input wire pwrite, // apb direction, high for write
   input wire [11:0] paddr, // apb byte address
   input wire [31:0] pwdata, // apb write data
   output reg [31:0] prdata, // apb read data
   output reg pready, // apb ready
   output reg pslverr, // apb error for unmapped address
   input wire autoTrigger, // auto trigger source
   input wire [9:0] sampleCode, // code from the analog comparator array
   output reg [4:0] activeChannel, // channel driving the multiplexer
   output reg [1:0] activeReference, // reference actually applied
   output reg internalRefOn, // internal reference powered
   output reg sampling, // conversion in progress
   output reg irq // level interrupt
);
   // ------------------------------------------------------------
   // states
   // ------------------------------------------------------------
   localparam [2:0] ST_IDLE = 3'b001; // waiting for a start
   localparam [2:0] ST_ARM = 3'b010; // start seen, waiting for adc edge
   localparam [2:0] ST_CONV = 3'b100; // converting

   reg [2:0] state; // one-hot state
   reg [7:0] selectBuf; // software visible select register
   reg [7:0] ctrl; // control register, start bit kept apart
   reg startPend; // start requested and busy indication
   reg freshEnable; // next conversion is the initialising one
   reg [4:0] cycLeft; // adc cycles remaining
   reg [9:0] result; // last converted code
   reg statusDone; // sticky completion status
   reg maskDone; // completion interrupt mask
   reg autoPrev; // previous auto trigger level
   reg presClear; // prescaler restart request
   reg isAutoConv; // current conversion began automatically
   reg [15:0] settleCnt; // gain stage settle timer
   wire adcTick; // adc clock edge pulse
   wire halfRate; // half-rate gain clock
   wire accessW; // write access completing
   wire accessR; // read access completing
   wire autoEdge; // rising edge of trigger source
   wire enabled; // converter enabled
   wire freeRun; // free running via auto enable without source
   reg [15:0] resultWord; // adjusted result

   assign accessW = psel & penable & pwrite & pready;
   assign accessR = psel & penable & ~pwrite & pready;
   assign enabled = ctrl[`ADCSEQ_EN_BIT];
   assign autoEdge = autoTrigger & ~autoPrev;
   // auto bit set on a software started run means free running
   assign freeRun = ctrl[`ADCSEQ_AUTO_BIT] & ~isAutoConv;

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   function isMapped;
      input [11:0] a;
      begin
         isMapped = (a == `ADCSEQ_ADDR_SELECT) ||
            (a == `ADCSEQ_ADDR_CONTROL) || (a == `ADCSEQ_ADDR_RESULT) ||
            (a == `ADCSEQ_ADDR_STATUS) || (a == `ADCSEQ_ADDR_MASK) ||
            (a == `ADCSEQ_ADDR_SAMPLE);
      end
   endfunction

   // ------------------------------------------------------------
   // result placement
   // ------------------------------------------------------------
   // adjust is applied at read time so changing it acts at once
   always @* begin
      if (selectBuf[`ADCSEQ_LADJ_BIT]) begin
         resultWord = {result, 6'b00_0000};
      end else begin
         resultWord = {6'b00_0000, result};
      end
   end

   // ------------------------------------------------------------
   // prescaler
   // ------------------------------------------------------------
   adcseq_prescaler uPresc (
      .clock(clock),
      .rst(rst),
      .clkEn(clkEn),
      .clear(presClear),
      .divSel(ctrl[`ADCSEQ_PRESC_HI:0]),
      .adcTick(adcTick),
      .halfRate(halfRate)
   );

   // ------------------------------------------------------------
   // apb slave: no wait states, so pready rises in the first access cycle
   // ------------------------------------------------------------
   always @(posedge clock) begin
      if (rst) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (clkEn) begin
         if (psel & ~penable) begin
            pready <= 1'b1;
            pslverr <= ~isMapped(paddr);
            case (paddr)
               `ADCSEQ_ADDR_SELECT: prdata <= {24'h00_0000, selectBuf};
               `ADCSEQ_ADDR_CONTROL: prdata <= {24'h00_0000, ctrl[7],
                  startPend, ctrl[5:0]};
               `ADCSEQ_ADDR_RESULT: prdata <= {16'h0000, resultWord};
               `ADCSEQ_ADDR_STATUS: prdata <= {31'h0000_0000, statusDone};
               `ADCSEQ_ADDR_MASK: prdata <= {31'h0000_0000, maskDone};
               `ADCSEQ_ADDR_SAMPLE: prdata <= {22'h00_0000, sampleCode};
               default: prdata <= 32'h0000_0000;
            endcase
         end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // software registers
   // ------------------------------------------------------------
   always @(posedge clock) begin
      if (rst) begin
         selectBuf <= `ADCSEQ_SELECT_RESET;
         ctrl <= 8'h00;
         maskDone <= 1'b0;
      end else if (clkEn && accessW) begin
         case (paddr)
            `ADCSEQ_ADDR_SELECT: selectBuf <= pwdata[7:0];
            `ADCSEQ_ADDR_CONTROL: ctrl <= {pwdata[7], 1'b0, pwdata[5:0]};
            `ADCSEQ_ADDR_MASK: maskDone <= pwdata[`ADCSEQ_DONE_BIT];
            default: ctrl <= ctrl;
         endcase
      end
   end

   // ------------------------------------------------------------
   // conversion sequencer
   // ------------------------------------------------------------
   always @(posedge clock) begin
      if (rst) begin
         state <= ST_IDLE;
         startPend <= 1'b0;
         freshEnable <= 1'b1;
         cycLeft <= 5'd0;
         result <= 10'h000;
         statusDone <= 1'b0;
         autoPrev <= 1'b0;
         presClear <= 1'b0;
         isAutoConv <= 1'b0;
         activeChannel <= 5'd0;
         activeReference <= `ADCSEQ_REF_EXTERNAL;
         internalRefOn <= 1'b0;
         sampling <= 1'b0;
         irq <= 1'b0;
      end else if (clkEn) begin
         autoPrev <= autoTrigger;
         presClear <= 1'b0;
         irq <= statusDone & maskDone;
         // selection follows the buffer unless a conversion holds it
         if (state != ST_CONV || cycLeft == 5'd1) begin
            activeChannel <= selectBuf[`ADCSEQ_CHAN_HI:0];
            activeReference <= selectBuf[7:6];
         end
         // reserved code keeps the internal reference off
         internalRefOn <= (activeReference == `ADCSEQ_REF_INTERNAL);
         // status clears by writing one, but a new completion wins
         if (accessW && paddr == `ADCSEQ_ADDR_STATUS &&
               pwdata[`ADCSEQ_DONE_BIT]) begin
            statusDone <= 1'b0;
         end
         if (accessW && paddr == `ADCSEQ_ADDR_CONTROL &&
               pwdata[`ADCSEQ_START_BIT] && pwdata[`ADCSEQ_EN_BIT]) begin
            startPend <= 1'b1;
         end
         if (!enabled) begin
            freshEnable <= 1'b1;
         end
         case (state)
            ST_IDLE: begin
               sampling <= 1'b0;
               if (enabled && ctrl[`ADCSEQ_AUTO_BIT] && autoEdge) begin
                  presClear <= 1'b1;
                  startPend <= 1'b1;
                  isAutoConv <= 1'b1;
                  state <= ST_ARM;
               end else if (startPend && enabled) begin
                  isAutoConv <= 1'b0;
                  state <= ST_ARM;
               end
            end
            ST_ARM: begin
               // begin on the next adc clock edge
               if (!enabled) begin
                  startPend <= 1'b0;
                  state <= ST_IDLE;
               end else if (adcTick && !presClear) begin
                  // a tick seen while the prescaler restarts is stale,
                  // so an auto start waits for the restarted divider
                  sampling <= 1'b1;
                  state <= ST_CONV;
                  freshEnable <= 1'b0;
                  if (freshEnable) begin
                     cycLeft <= `ADCSEQ_CYC_FIRST;
                  end else if (ctrl[`ADCSEQ_DIFF_BIT] && halfRate) begin
                     cycLeft <= `ADCSEQ_CYC_SYNC;
                  end else begin
                     cycLeft <= `ADCSEQ_CYC_NORMAL;
                  end
               end
            end
            ST_CONV: begin
               if (!enabled) begin
                  // disabling aborts the conversion with no result
                  startPend <= 1'b0;
                  sampling <= 1'b0;
                  state <= ST_IDLE;
               end else if (adcTick) begin
                  if (cycLeft == 5'd1) begin
                     result <= sampleCode;
                     statusDone <= 1'b1;
                     if (freeRun) begin
                        // free running restart, gain clock now high
                        cycLeft <= ctrl[`ADCSEQ_DIFF_BIT] ?
                           `ADCSEQ_CYC_SYNC : `ADCSEQ_CYC_NORMAL;
                     end else begin
                        startPend <= 1'b0;
                        sampling <= 1'b0;
                        state <= ST_IDLE;
                     end
                  end else begin
                     cycLeft <= cycLeft - 5'd1;
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
endmodule // adcseq_sequencer

// *** dv/adcseq_monitor.sv ***
// port checker for the conversion sequencer
`timescale 1ns/100ps
`include "adcseq_regs.vh"
module adcseq_monitor (
   input wire clock, // system clock
   input wire rst, // sync reset
   input wire clkEn, // freeze when low
   input wire psel, // apb select
   input wire penable, // apb access
   input wire pwrite, // apb write
   input wire [11:0] paddr, // apb address
   input wire [31:0] pwdata, // apb write data
   input wire [31:0] prdata, // apb read data
   input wire pready, // apb ready
   input wire pslverr, // apb error
   input wire autoTrigger, // trigger source
   input wire [9:0] sampleCode, // comparator code
   input wire [4:0] activeChannel, // applied channel
   input wire [1:0] activeReference, // applied reference
   input wire internalRefOn, // internal ref power
   input wire sampling, // converting
   input wire irq // interrupt
);
   // ----------------------------------------
   // assertions, all in the system clock domain
   // ----------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   wire startWr = psel && penable && pwrite && pwdata[7] && pwdata[6]
      && paddr == `ADCSEQ_ADDR_CONTROL; // enable plus start write
   AST_READY_SETUP: assert property (clkEn && psel && !penable |=> pready)
      else $error("no ready after setup");
   AST_ERR_WITH_READY: assert property (pslverr |-> pready)
      else $error("error without ready");
   AST_RESET_IDLE: assert property (disable iff (1'b0)
      rst |=> !sampling && !irq && activeReference == 2'h0)
      else $error("outputs not idle after reset");
   // slowest prescale gives 128 cycles before the next adc edge
   AST_START_SOON: assert property (startWr && !sampling
      |-> ##[1:300] sampling) else $error("start not taken");
   AST_MIN_LENGTH: assert property ($rose(sampling) |-> sampling[*8])
      else $error("conversion too short");
   AST_HOLD_SELECT: assert property ($rose(sampling)
      |=> $stable(activeChannel)[*2]) else $error("channel moved");
   AST_REF_INTERNAL: assert property (activeReference == 2'h3
      && $past(activeReference) == 2'h3 |-> internalRefOn)
      else $error("internal reference off");
   AST_REF_EXTERNAL: assert property (activeReference == 2'h0
      && $past(activeReference) == 2'h0 |-> !internalRefOn)
      else $error("internal reference on");
   COV_DONE: cover property ($fell(sampling));
   COV_IRQ: cover property ($rose(irq));
   COV_ERR: cover property (pslverr);
endmodule // adcseq_monitor

bind adcseq_sequencer adcseq_monitor adcseq_monitor_inst (.clock(clock),
   .rst(rst), .clkEn(clkEn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .autoTrigger(autoTrigger),
   .sampleCode(sampleCode), .activeChannel(activeChannel),
   .activeReference(activeReference), .internalRefOn(internalRefOn),
   .sampling(sampling), .irq(irq));

// *** dv/adcseq_sequencer_tb.sv ***
// self-checking bench for the conversion sequencer
`timescale 1ns/100ps
`include "adcseq_regs.vh"
module adcseq_sequencer_tb;
   logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic autoTrigger = 0, pready, pslverr, internalRefOn, sampling, irq, e;
   logic [11:0] paddr = 12'h000; // apb address
   logic [31:0] pwdata = 32'h0000_0000, prdata, q; // q holds read data
   logic [9:0] sampleCode = 10'h000; // fake comparator code
   logic [4:0] activeChannel;
   logic [1:0] activeReference;
   int n_fail = 0, checked = 0, len, wt; // len, wt in clocks
   time t0; // time of a free running completion
   always #20 clock = ~clock;
   adcseq_sequencer adcseq_sequencer_inst (.clock(clock), .rst(rst),
      .clkEn(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .autoTrigger(autoTrigger),
      .sampleCode(sampleCode), .activeChannel(activeChannel),
      .activeReference(activeReference), .internalRefOn(internalRefOn),
      .sampling(sampling), .irq(irq));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task summarize;
      if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task rng(input int v, input int lo, input int hi);
      checked++;
      if (v < lo || v > hi) begin
         n_fail++;
         $display("BAD %0t count %0d not in %0d..%0d", $time, v, lo, hi);
      end
   endtask
   // one apb transfer; request held until ready is seen at an edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do @(posedge clock); while (pready !== 1'b1 && ++n < 20);
      if (pready !== 1'b1) begin
         n_fail++;
         $display("BAD %0t no ready", $time);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // bounded wait for the busy level, wait length kept in wt
   task waitFor(input logic lvl);
      wt = 0;
      while (sampling !== lvl && wt < 400) begin
         @(posedge clock);
         wt++;
      end
   endtask
   // bounded wait for the interrupt level, wait length kept in wt
   task waitIrq(input logic lvl);
      wt = 0;
      while (irq !== lvl && wt < 400) begin
         @(posedge clock);
         wt++;
      end
   endtask
   task meas;
      waitFor(1'b1);
      len = 0;
      while (sampling === 1'b1 && len < 2000) begin
         @(posedge clock);
         len++;
      end
   endtask
   // prescale 0 divides by two, so one adc cycle is two clocks
   task conv(input logic [31:0] ctl);
      apb(1'b1, `ADCSEQ_ADDR_CONTROL, ctl);
      meas;
      repeat (2) @(posedge clock);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task tRegs;
      apb(1'b0, `ADCSEQ_ADDR_SELECT, 0);
      chk(q, 32'h0000_0000);
      apb(1'b1, `ADCSEQ_ADDR_SELECT, 32'h0000_00FF);
      apb(1'b0, `ADCSEQ_ADDR_SELECT, 0);
      chk(q, 32'h0000_00FF);
      chk(activeChannel, 32'h0000_001F);
      // the reserved code must leave the internal reference off
      for (int r = 0; r < 4; r++) begin
         apb(1'b1, `ADCSEQ_ADDR_SELECT, r << 6);
         repeat (3) @(posedge clock);
         chk(activeReference, r);
         chk(internalRefOn, r == 3);
      end
      apb(1'b0, 12'h0FC, 0);
      chk(e, 1);
      chk(q, 0);
   endtask
   task tFirst;
      apb(1'b1, `ADCSEQ_ADDR_SELECT, 32'h0000_0023);
      sampleCode <= 10'h270;
      conv(32'h0000_00C0);
      rng(len, 49, 51);
      apb(1'b0, `ADCSEQ_ADDR_RESULT, 0);
      chk(q, 32'h0000_9C00);
      apb(1'b0, `ADCSEQ_ADDR_STATUS, 0);
      chk(q, 32'h0000_0001);
      chk(irq, 0); // masked, so quiet
      apb(1'b1, `ADCSEQ_ADDR_MASK, 32'h0000_0001);
      repeat (2) @(posedge clock);
      chk(irq, 1);
      apb(1'b1, `ADCSEQ_ADDR_STATUS, 32'h0000_0001);
      repeat (2) @(posedge clock);
      chk(irq, 0); // write one clears the flag
   endtask
   task tCodes;
      logic [9:0] codes [3] = '{10'h1FF, 10'h3FF, 10'h200};
      apb(1'b1, `ADCSEQ_ADDR_SELECT, 32'h0000_0000);
      foreach (codes[i]) begin
         sampleCode <= codes[i];
         conv(32'h0000_00C0);
         rng(len, 25, 27);
         apb(1'b0, `ADCSEQ_ADDR_RESULT, 0);
         chk(q, {22'h0, codes[i]});
      end
      // prescale 2 divides by four: 13 adc cycles are 52 clocks
      conv(32'h0000_00C2);
      rng(len, 51, 53);
   endtask
   // selection written mid conversion must wait for its last adc cycle
   task tFreeze;
      apb(1'b1, `ADCSEQ_ADDR_CONTROL, 32'h0000_00C0);
      waitFor(1'b1);
      apb(1'b1, `ADCSEQ_ADDR_SELECT, 32'h0000_00C7);
      repeat (2) @(posedge clock);
      chk(activeReference, 0);
      chk(activeChannel, 0);
      // the new channel must appear while still converting
      wt = 0;
      while (activeChannel !== 5'd7 && wt < 400) begin
         @(posedge clock);
         wt++;
      end
      chk(sampling, 1);
      waitFor(1'b0);
      repeat (2) @(posedge clock);
      chk(activeReference, 3);
      chk(activeChannel, 7);
   endtask
   task tModes;
      // selection changed last scenario: let the gain stage settle
      repeat (`ADCSEQ_SETTLE_CYC) @(posedge clock);
      conv(32'h0000_00D0);
      rng(len, 25, 29);
      // free running never drops busy, so time it by completions
      apb(1'b1, `ADCSEQ_ADDR_STATUS, 32'h0000_0001);
      apb(1'b1, `ADCSEQ_ADDR_CONTROL, 32'h0000_00F0);
      waitIrq(1'b1);
      t0 = $time;
      apb(1'b1, `ADCSEQ_ADDR_STATUS, 32'h0000_0001);
      waitIrq(1'b0);
      waitIrq(1'b1);
      len = ($time - t0) / 40;
      chk(sampling, 1);
      rng(len, 27, 29);
      apb(1'b1, `ADCSEQ_ADDR_CONTROL, 32'h0000_0000);
      waitFor(1'b0);
      apb(1'b1, `ADCSEQ_ADDR_CONTROL, 32'h0000_00B0);
      autoTrigger <= 1'b1;
      meas;
      // restarted divider puts the start six clocks after the trigger
      rng(wt, 6, 6);
      rng(len, 49, 51);
      autoTrigger <= 1'b0;
      apb(1'b1, `ADCSEQ_ADDR_CONTROL, 32'h0000_0000);
   endtask
   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      tRegs;
      tFirst;
      tCodes;
      tFreeze;
      tModes;
      summarize;
   end
   // the whole run needs a few thousand clocks; allow 20000
   initial begin
      #800000;
      n_fail++;
      summarize;
   end
endmodule // adcseq_sequencer_tb
